// File: pm_signaling_defines.vh
// Constants for the power management signaling block.
`ifndef PM_SIGNALING_DEFINES_VH
`define PM_SIGNALING_DEFINES_VH
`define PM_CAP_OFFSET        4'h0
`define PM_CTRL_OFFSET       4'h4
`define PM_STATUS_OFFSET     4'h8
`define PM_CAP_RESET         32'h00000000
`define POWER_REPORT_BUS_MSB          31
`define POWER_REPORT_BUS_LSB          24
`define PM_STATUS_BIT        15
`define PM_SCALE_MSB         14
`define PM_SCALE_LSB         13
`define PM_SELECT_MSB        12
`define PM_SELECT_LSB        9
`define PM_ENABLE_BIT        8
`define PM_DSTATE_MSB        1
`define PM_DSTATE_LSB        0
`define PM_D3_CODE           2'h3
`define PM_TYPE_AUX          2'h1
`define PM_TYPE_PME_AUX      2'h2
`define PM_PWR_VALUE_MSB     9
`define PM_PWR_VALUE_LSB     2
`define PM_PWR_SCALE_MSB     1
`define PM_PWR_SCALE_LSB     0
`endif

// File: pm_sync2.v
// Two flip-flop synchroniser for one level signal.
`default_nettype none
module pm_sync2
(
  // Clock and reset
  input  wire i_clock,
  input  wire i_sys_rst,
  // Data
  input  wire i_async,
  output reg  o_sync
);
  reg stage_one;
  always @(posedge i_clock)
  begin
    if (i_sys_rst)
    begin
      stage_one <= 1'b0;
      o_sync    <= 1'b0;
    end
    else
    begin
      stage_one <= i_async;
      o_sync    <= stage_one;
    end
  end
endmodule
`default_nettype wire

// File: pm_signaling.v
// Power management turn-off, wake event and capability register logic.
//
// Contract
// - Root Port: turn-off control request sends a turn-off message.
// - Endpoint: turn-off control acknowledges; core sends the acknowledge message.
// - Root Port: status pulses one cycle when acknowledge message arrives.
// - Endpoint: status pulses one cycle when turn-off message arrives.
// - Wake event request exists only in the Endpoint role.
// - Wake request rising edge sends one event message; holding does not repeat.
// - In low power, link is woken first, then the event message goes.
// - Power bus bits 1:0 carry scale: unknown, 0.1, 0.01, 0.001.
// - Power bus used only when all three aux power bits are zero.
// - Register bits 31:24 hold data value; bits 22:16 reserved.
// - Register bit 15 is the event status flag.
// - Register bits 14:13 hold scale, read-only to writes.
// - Register bits 12:9 select reported quantity.
// - Register bit 8 is event enable; bits 7:2 reserved.
// - Register bits 1:0 hold device power state D0 to D3.
// - D3 code with aux type means D3-Cold, otherwise D3-Hot.
`default_nettype none
`include "pm_signaling_defines.vh"
module pm_signaling
#(
  parameter IS_ENDPOINT = 1,
  parameter [2:0] AUX_POWER_BITS = 3'h0
)
(
  // Clock and reset
  input  wire        i_clock,
  input  wire        i_sys_rst,
  // Register port
  input  wire [3:0]  i_addr,
  input  wire [31:0] i_wdata,
  input  wire        i_wr,
  input  wire        i_rd,
  output reg  [31:0] o_rdata,
  // Application side
  input  wire        i_turnoff_ctrl_in,
  output reg         o_turnoff_status_out,
  input  wire        i_wake_event_req,
  input  wire [9:0]  i_power_report_bus,
  input  wire        i_aux_supply_ind,
  input  wire [1:0]  i_type_code,
  // Link side
  input  wire        i_rx_turnoff_msg,
  input  wire        i_rx_turnoff_ack_msg,
  input  wire        i_link_low_power,
  input  wire        i_link_active,
  output reg         o_tx_turnoff_msg,
  output reg         o_tx_turnoff_ack_msg,
  output reg         o_tx_pme_msg,
  output reg         o_link_wake_req,
  output reg         o_d3_cold,
  output reg         o_d3_hot
);
  // ==========================================================================
  // Input synchronisers
  wire ctrl_sync;
  wire event_sync;
  pm_sync2 u_sync_ctrl
  (
    .i_clock   (i_clock),
    .i_sys_rst (i_sys_rst),
    .i_async   (i_turnoff_ctrl_in),
    .o_sync    (ctrl_sync)
  );
  pm_sync2 u_sync_event
  (
    .i_clock   (i_clock),
    .i_sys_rst (i_sys_rst),
    .i_async   (i_wake_event_req),
    .o_sync    (event_sync)
  );

  // ==========================================================================
  // Edge detection
  reg ctrl_prev;
  reg event_prev;
  wire ctrl_rise;
  wire event_rise;
  assign ctrl_rise  = ctrl_sync & ~ctrl_prev;
  assign event_rise = (IS_ENDPOINT != 0) & event_sync & ~event_prev;

  // ==========================================================================
  // Registers
  reg        pme_status;
  reg        pme_enable;
  reg [3:0]  data_select;
  reg [1:0]  power_state;
  reg        turnoff_pending;
  wire       power_bus_used;
  wire [7:0] data_value;
  wire [1:0] data_scale;
  wire [31:0] cap_word;
  wire [31:0] status_word;
  assign power_bus_used = (AUX_POWER_BITS == 3'h0);
  assign data_value = power_bus_used ?
    i_power_report_bus[`PM_PWR_VALUE_MSB:`PM_PWR_VALUE_LSB] : 8'h00;
  assign data_scale = power_bus_used ?
    i_power_report_bus[`PM_PWR_SCALE_MSB:`PM_PWR_SCALE_LSB] : 2'h0;
  assign cap_word = {data_value, 1'b0, 7'h00, pme_status, data_scale,
                     data_select, pme_enable, 6'h00, power_state};
  assign status_word = {26'h0000000, o_d3_hot, o_d3_cold, o_link_wake_req,
                        turnoff_pending, i_aux_supply_ind, o_turnoff_status_out};

  // ==========================================================================
  // Wake sequencer states
  localparam [2:0] ST_IDLE = 3'h1;
  localparam [2:0] ST_WAKE = 3'h2;
  localparam [2:0] ST_SEND = 3'h4;
  reg [2:0] state;
  reg [2:0] next_state;
  always @*
  begin
    next_state = state;
    case (state)
      ST_IDLE:
      begin
        if (event_rise)
          next_state = i_link_low_power ? ST_WAKE : ST_SEND;
      end
      ST_WAKE:
      begin
        if (i_link_active)
          next_state = ST_SEND;
      end
      ST_SEND:
      begin
        next_state = ST_IDLE;
      end
      default:
      begin
        next_state = ST_IDLE;
      end
    endcase
  end

  // ==========================================================================
  // Role decode.
  wire is_endpoint;
  assign is_endpoint = (IS_ENDPOINT != 0);

  // ==========================================================================
  // Type decode shared by the cold and hot state outputs.
  function is_aux_type;
    input [1:0] code;
    begin
      is_aux_type = (code == `PM_TYPE_AUX) || (code == `PM_TYPE_PME_AUX);
    end
  endfunction

  // ==========================================================================
  // Edge history and sequencer state.
  always @(posedge i_clock)
  begin
    if (i_sys_rst)
    begin
      ctrl_prev  <= 1'b0;
      event_prev <= 1'b0;
      state      <= ST_IDLE;
    end
    else
    begin
      ctrl_prev  <= ctrl_sync;
      event_prev <= event_sync;
      state      <= next_state;
    end
  end

  // ==========================================================================
  // Turn-off message handshake.
  always @(posedge i_clock)
  begin
    if (i_sys_rst)
    begin
      o_tx_turnoff_msg     <= 1'b0;
      o_tx_turnoff_ack_msg <= 1'b0;
      o_turnoff_status_out <= 1'b0;
    end
    else
    begin
      o_tx_turnoff_msg     <= ~is_endpoint & ctrl_rise;
      o_tx_turnoff_ack_msg <= is_endpoint & ctrl_rise & turnoff_pending;
      o_turnoff_status_out <= is_endpoint ? i_rx_turnoff_msg
                                          : i_rx_turnoff_ack_msg;
    end
  end

  // ==========================================================================
  // Pending flag: a received turn-off message waits here for its acknowledge.
  always @(posedge i_clock)
  begin
    if (i_sys_rst)
    begin
      turnoff_pending <= 1'b0;
    end
    else if (is_endpoint && i_rx_turnoff_msg)
    begin
      turnoff_pending <= 1'b1;
    end
    else if (ctrl_rise)
    begin
      turnoff_pending <= 1'b0;
    end
  end

  // ==========================================================================
  // Wake request and event message outputs.
  always @(posedge i_clock)
  begin
    if (i_sys_rst)
    begin
      o_link_wake_req <= 1'b0;
      o_tx_pme_msg    <= 1'b0;
    end
    else
    begin
      o_link_wake_req <= (next_state == ST_WAKE);
      o_tx_pme_msg    <= (next_state == ST_SEND) & pme_enable;
    end
  end

  // ==========================================================================
  // Event status flag; a new event wins over a clear in the same cycle.
  always @(posedge i_clock)
  begin
    if (i_sys_rst)
    begin
      pme_status <= 1'b0;
    end
    else if (event_rise)
    begin
      pme_status <= 1'b1;
    end
    else if (i_wr && (i_addr == `PM_CAP_OFFSET) && i_wdata[`PM_STATUS_BIT])
    begin
      pme_status <= 1'b0;
    end
  end

  // ==========================================================================
  // Writable fields; the scale field is not stored, so writes cannot change it.
  always @(posedge i_clock)
  begin
    if (i_sys_rst)
    begin
      pme_enable  <= 1'b0;
      data_select <= 4'h0;
      power_state <= 2'h0;
    end
    else if (i_wr && (i_addr == `PM_CAP_OFFSET))
    begin
      pme_enable  <= i_wdata[`PM_ENABLE_BIT];
      data_select <= i_wdata[`PM_SELECT_MSB:`PM_SELECT_LSB];
      power_state <= i_wdata[`PM_DSTATE_MSB:`PM_DSTATE_LSB];
    end
  end

  // ==========================================================================
  // Cold and hot power state outputs.
  always @(posedge i_clock)
  begin
    if (i_sys_rst)
    begin
      o_d3_cold <= 1'b0;
      o_d3_hot  <= 1'b0;
    end
    else
    begin
      o_d3_cold <= (power_state == `PM_D3_CODE) && is_aux_type(i_type_code);
      o_d3_hot  <= (power_state == `PM_D3_CODE) && !is_aux_type(i_type_code);
    end
  end

  // ==========================================================================
  // Read data, valid only in the cycle after the read strobe.
  always @(posedge i_clock)
  begin
    if (i_sys_rst)
    begin
      o_rdata <= 32'h00000000;
    end
    else if (i_rd)
    begin
      case (i_addr)
        `PM_CAP_OFFSET:
        begin
          o_rdata <= cap_word;
        end
        `PM_STATUS_OFFSET:
        begin
          o_rdata <= status_word;
        end
        default:
        begin
          o_rdata <= 32'h00000000;
        end
      endcase
    end
    else
    begin
      o_rdata <= 32'h00000000;
    end
  end
endmodule
`default_nettype wire

// File: pm_signaling_props.sv
// Assertion checker for the power management signaling block.
`default_nettype none
module pm_signaling_props
#(
  parameter int IS_ENDPOINT = 1
)
(
  input wire logic       i_clock, i_sys_rst, i_turnoff_ctrl_in, i_wake_event_req,
  input wire logic       i_rx_turnoff_ack_msg,
  input wire logic       i_rx_turnoff_msg, i_link_active, o_turnoff_status_out,
  input wire logic       o_tx_turnoff_msg, o_tx_turnoff_ack_msg, o_tx_pme_msg,
  input wire logic       o_link_wake_req, o_d3_cold, o_d3_hot,
  input wire logic [1:0] i_type_code
);
  // ==========
  // Checks.
  default clocking @(posedge i_clock); endclocking
  default disable iff (i_sys_rst);
  wire status_src;
  assign status_src = (IS_ENDPOINT != 0) ? i_rx_turnoff_msg : i_rx_turnoff_ack_msg;
  status_pulse_a: assert property (status_src |=> o_turnoff_status_out)
    else $error("status pulse missing");
  status_cause_a: assert property (o_turnoff_status_out |-> $past(status_src))
    else $error("status pulse without message");
  ack_cause_a: assert property (o_tx_turnoff_ack_msg |->
    IS_ENDPOINT != 0 && $past(i_turnoff_ctrl_in, 2))
    else $error("ack without control");
  pme_cause_a: assert property (o_tx_pme_msg |->
    IS_ENDPOINT != 0 && $past(i_wake_event_req, 2))
    else $error("event message without request");
  pme_single_a: assert property (o_tx_pme_msg |=> !o_tx_pme_msg)
    else $error("event message repeated");
  wake_hold_a: assert property (o_link_wake_req && !i_link_active |=> o_link_wake_req)
    else $error("wake request dropped early");
  d3_kind_a: assert property (o_d3_cold |-> !o_d3_hot && $past(i_type_code) inside {2'h1, 2'h2})
    else $error("wrong cold state");
  rp_silent_a: assert property (o_tx_turnoff_msg |->
    IS_ENDPOINT == 0 && $past(i_turnoff_ctrl_in, 2))
    else $error("turn-off sent without control or by endpoint");
endmodule
bind pm_signaling pm_signaling_props #(.IS_ENDPOINT(IS_ENDPOINT)) u_props (.i_clock,
  .i_sys_rst, .i_turnoff_ctrl_in, .i_rx_turnoff_ack_msg,
  .i_wake_event_req, .i_rx_turnoff_msg, .i_link_active, .o_turnoff_status_out,
  .o_tx_turnoff_msg, .o_tx_turnoff_ack_msg, .o_tx_pme_msg, .o_link_wake_req,
  .o_d3_cold, .o_d3_hot, .i_type_code);
`default_nettype wire

// File: pm_link_model.sv
// Link partner model: turn-off message source and slow wake responder.
`default_nettype none
module pm_link_model
#(
  parameter int WAKE_DELAY = 6
)
(
  input wire logic i_clock, i_sys_rst, i_send_off, i_sleep, o_link_wake_req,
  output var logic o_rx_off, o_low_power, o_active
);
  logic [3:0] cnt;
  always @(posedge i_clock)
  begin
    o_rx_off <= i_send_off & ~i_sys_rst;
    if (i_sys_rst | i_sleep)
    begin
      cnt <= 4'h0;
      o_low_power <= i_sleep;
      o_active <= ~i_sleep;
    end
    else if (o_link_wake_req && !o_active)
    begin
      cnt <= cnt + 4'h1;
      o_active <= (cnt == WAKE_DELAY - 1);
      o_low_power <= (cnt != WAKE_DELAY - 1);
    end
  end
endmodule
`default_nettype wire

// File: pm_signaling_tb.sv
// Self-checking testbench for the power management signaling block.
`default_nettype none
module pm_signaling_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic i_clock = 0, i_sys_rst = 1, i_wr = 0, i_rd = 0, ctrl = 0, wake = 0;
  logic aux = 1, send_off = 0, sleep = 0, rx_off, low_pw, active;
  logic o_stat, o_tx_off, o_ack, o_pme, o_wreq, o_cold, o_hot;
  logic [3:0] i_addr = 4'h0;
  logic [31:0] i_wdata = 32'h0, o_rdata;
  logic [9:0] pwr = {8'h72, 2'h2};
  logic [1:0] typ = 2'h0;
  logic [7:0] n_stat = 8'h0, n_ack = 8'h0, n_pme = 8'h0;
  logic rp_ctrl = 0, rp_ack = 0, o_rp_stat, o_rp_off, o_rp_pme;
  logic [7:0] n_rp_off = 8'h0, n_rp_stat = 8'h0, n_rp_pme = 8'h0;
  int n_mismatch = 0, compares = 0;
  pm_signaling u_dut (.i_clock, .i_sys_rst, .i_addr, .i_wdata, .i_wr, .i_rd, .o_rdata,
    .i_turnoff_ctrl_in(ctrl), .o_turnoff_status_out(o_stat), .i_wake_event_req(wake),
    .i_power_report_bus(pwr), .i_aux_supply_ind(aux), .i_type_code(typ),
    .i_rx_turnoff_msg(rx_off), .i_rx_turnoff_ack_msg(1'b0), .i_link_low_power(low_pw),
    .i_link_active(active), .o_tx_turnoff_msg(o_tx_off), .o_tx_turnoff_ack_msg(o_ack),
    .o_tx_pme_msg(o_pme), .o_link_wake_req(o_wreq), .o_d3_cold(o_cold), .o_d3_hot(o_hot));
  pm_signaling #(.IS_ENDPOINT(0)) u_dut_rp (.i_clock, .i_sys_rst, .i_addr, .i_wdata, .i_wr,
    .i_rd, .o_rdata(), .i_turnoff_ctrl_in(rp_ctrl), .o_turnoff_status_out(o_rp_stat),
    .i_wake_event_req(wake), .i_power_report_bus(pwr), .i_aux_supply_ind(aux),
    .i_type_code(typ), .i_rx_turnoff_msg(1'b0), .i_rx_turnoff_ack_msg(rp_ack),
    .i_link_low_power(1'b0), .i_link_active(1'b1), .o_tx_turnoff_msg(o_rp_off),
    .o_tx_turnoff_ack_msg(), .o_tx_pme_msg(o_rp_pme), .o_link_wake_req(), .o_d3_cold(),
    .o_d3_hot());
  pm_link_model u_link (.i_clock, .i_sys_rst, .i_send_off(send_off), .i_sleep(sleep),
    .o_link_wake_req(o_wreq), .o_rx_off(rx_off), .o_low_power(low_pw), .o_active(active));
  // ==========
  // Clock, pulse counters and tasks.
  initial forever #20 i_clock = ~i_clock;
  always @(posedge i_clock)
  begin
    if (i_sys_rst)
    begin
      n_stat <= 8'h0;
      n_ack <= 8'h0;
      n_pme <= 8'h0;
      n_rp_off <= 8'h0;
      n_rp_stat <= 8'h0;
      n_rp_pme <= 8'h0;
    end
    else
    begin
      n_stat <= n_stat + o_stat;
      n_ack <= n_ack + o_ack;
      n_pme <= n_pme + o_pme;
      n_rp_off <= n_rp_off + o_rp_off;
      n_rp_stat <= n_rp_stat + o_rp_stat;
      n_rp_pme <= n_rp_pme + o_rp_pme;
    end
  end
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge i_clock);
    i_addr <= a;
    i_wdata <= d;
    i_wr <= 1'b1;
    @(posedge i_clock);
    i_wr <= 1'b0;
  endtask
  task rd(input logic [3:0] a, input logic [31:0] exp);
    @(posedge i_clock);
    i_addr <= a;
    i_rd <= 1'b1;
    @(posedge i_clock);
    i_rd <= 1'b0;
    @(negedge i_clock);
    chk(o_rdata, exp);
  endtask
  task end_sim;
    $display("compares %0d mismatches %0d", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  initial
  begin
    #100000;
    n_mismatch++;
    end_sim;
  end
  // ==========
  // Test sequence.
  initial
  begin
    repeat (5) @(posedge i_clock);
    i_sys_rst <= 1'b0;
    rd(4'h0, 32'h72004000);
    wr(4'h0, 32'hffffffff);
    rd(4'h0, 32'h72005f03);
    rd(4'hc, 32'h0);
    @(posedge i_clock) typ <= 2'h1;
    repeat (3) @(negedge i_clock);
    chk({o_cold, o_hot}, 32'h2);
    @(posedge i_clock) typ <= 2'h0;
    repeat (3) @(negedge i_clock);
    chk({o_cold, o_hot}, 32'h1);
    @(posedge i_clock) send_off <= 1'b1;
    @(posedge i_clock) send_off <= 1'b0;
    repeat (4) @(negedge i_clock);
    chk(n_stat, 32'h1);
    @(posedge i_clock) ctrl <= 1'b1;
    repeat (12) @(negedge i_clock);
    chk(n_ack, 32'h1);
    @(posedge i_clock) wake <= 1'b1;
    repeat (20) @(negedge i_clock);
    chk(n_pme, 32'h1);
    rd(4'h0, 32'h7200df03);
    wr(4'h0, 32'h00009f03);
    rd(4'h0, 32'h72005f03);
    wake <= 1'b0;
    sleep <= 1'b1;
    @(posedge i_clock) sleep <= 1'b0;
    wake <= 1'b1;
    repeat (5) @(negedge i_clock);
    chk({o_wreq, n_pme}, {23'h0, 1'b1, 8'h1});
    repeat (20) @(negedge i_clock);
    chk({o_wreq, n_pme}, {23'h0, 1'b0, 8'h2});
    rd(4'h8, 32'h22);
    @(posedge i_clock) rp_ctrl <= 1'b1;
    repeat (6) @(negedge i_clock);
    chk(n_rp_off, 32'h1);
    @(posedge i_clock) rp_ack <= 1'b1;
    @(posedge i_clock) rp_ack <= 1'b0;
    repeat (3) @(negedge i_clock);
    chk(n_rp_stat, 32'h1);
    chk(n_rp_pme, 32'h0);
    end_sim;
  end
endmodule
`default_nettype wire
